// *** verilog/timer_cmp_pkg.sv ***
// constants of the output compare timer block: addresses, fields, reset values
// assumes a 32-bit apb bus with byte addresses
package timer_cmp_pkg;

    // bus widths
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // counter widths and channel counts
    localparam int TIMER_W = 24;
    localparam int PWM_W = 16;
    localparam int NUM_CMP = 2;
    localparam int NUM_PWM = 4;

    // register byte addresses
    localparam logic [31:0] COMPARE0_VALUE_ADDR = 32'hfff7fd24;
    localparam logic [31:0] COMPARE1_VALUE_ADDR = 32'hfff7fd28;
    localparam logic [31:0] COMPARE0_CONTROL_ADDR = 32'hfff7fd2c;
    localparam logic [31:0] COMPARE1_CONTROL_ADDR = 32'hfff7fd30;
    localparam logic [31:0] PWM0_COUNT_VALUE_ADDR = 32'hfff7fd34;
    localparam logic [31:0] PWM1_COUNT_VALUE_ADDR = 32'hfff7fd58;
    localparam logic [31:0] PWM2_COUNT_VALUE_ADDR = 32'hfff7fd6c;
    localparam logic [31:0] PWM3_COUNT_VALUE_ADDR = 32'hfff7fd80;
    localparam logic [31:0] TIMER_CONTROL_ADDR = 32'hfff7fd90;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'hfff7fd94;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'hfff7fd98;
    localparam logic [31:0] TIMER_COUNT_ADDR = 32'hfff7fd9c;

    // compare control fields
    localparam int CMP_EVENT_FLAG_BIT = 0;
    localparam int CMP_IRQ_ENABLE_BIT = 1;

    // timer control fields
    localparam int CLK_SRC_SEL_BIT = 0;
    localparam int PWM_RUN_LSB = 4;
    localparam int TIMER_CTRL_W = 8;

    // reset values
    localparam logic [23:0] COMPARE_VALUE_RESET = 24'h000000;
    localparam logic [7:0] TIMER_CTRL_RESET = 8'h00;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    // clock
    localparam int CLK_PERIOD_NS = 100;

endpackage

// *** verilog/step_counter.sv ***
// free-running up counter with an advance enable
// assumes enable is a one-cycle pulse or level on clk
`timescale 1ns/1ns
module step_counter
    import timer_cmp_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic enable,
    output logic [W-1:0] count,
    output logic stepped
);

    // count advances and marks the cycle in which the new value is seen
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            stepped <= 1'b0;
        end else begin
            stepped <= enable;
            if (enable) begin
                count <= count + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

// *** verilog/compare_channel.sv ***
// one output compare channel: compare value, enable and sticky event flag
// assumes write strobes are one-cycle pulses from the bus slave
`timescale 1ns/1ns
module compare_channel
    import timer_cmp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [TIMER_W-1:0] timer_count,
    input wire logic timer_stepped,
    input wire logic value_wr,
    input wire logic control_wr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [TIMER_W-1:0] compare_value_reg,
    output logic compare_irq_enable_reg,
    output logic compare_event_flag_reg,
    output logic compare_event_reg,
    output logic compare_irq_reg
);

    // match only on the cycle the counter shows a new value
    wire match = timer_stepped && (timer_count == compare_value_reg);
    wire w1c = control_wr && wdata[CMP_EVENT_FLAG_BIT];
    wire flag_clear = w1c || value_wr;
    wire flag_next = match || (compare_event_flag_reg && !flag_clear);
    wire enable_next = control_wr ? wdata[CMP_IRQ_ENABLE_BIT] : compare_irq_enable_reg;

    // channel state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            compare_value_reg <= COMPARE_VALUE_RESET;
            compare_irq_enable_reg <= 1'b0;
            compare_event_flag_reg <= 1'b0;
            compare_event_reg <= 1'b0;
            compare_irq_reg <= 1'b0;
        end else begin
            if (value_wr) begin
                compare_value_reg <= wdata[TIMER_W-1:0];
            end
            compare_irq_enable_reg <= enable_next;
            compare_event_flag_reg <= flag_next;
            compare_event_reg <= match;
            compare_irq_reg <= flag_next && enable_next;
        end
    end

endmodule

// *** verilog/timer_compare_top.sv ***
// output compare block of a 24-bit timer, apb slave with interrupt status
// assumes apb3 master on clk, ext_clk_pin asynchronous to clk
//
// Function
// - each compare channel has a 24-bit read/write compare value resetting to zero.
// - a second compare channel has its own compare value and control register.
// - control bit 1 enables the channel interrupt request and resets to zero.
// - control bit 0 is a sticky compare event flag resetting to zero.
// - writing one to the flag bit clears it, writing zero leaves it.
// - writing the channel compare value also clears its flag.
// - a compare event in the same cycle as a clear leaves the flag set.
// - the four 16-bit pwm counters are each readable at their own address.
// - the 24-bit counter runs on the internal clock or, when selected, the external clock.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module timer_compare_top
    import timer_cmp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clk_pin,
    output logic [NUM_CMP-1:0] cmp_irq,
    output logic irq
);

    // external clock pin synchroniser and edge detect
    logic ext_sync1_reg;
    logic ext_sync2_reg;
    logic ext_prev_reg;

    // software control state
    logic [TIMER_CTRL_W-1:0] timer_ctrl_reg;
    logic [NUM_CMP-1:0] irq_status_reg;
    logic [NUM_CMP-1:0] irq_status_next;
    logic [NUM_CMP-1:0] irq_mask_reg;

    // counters
    logic [TIMER_W-1:0] timer_count;
    logic timer_stepped;
    logic [PWM_W-1:0] pwm_count [NUM_PWM];

    // channel outputs
    logic [TIMER_W-1:0] cmp_value [NUM_CMP];
    logic [NUM_CMP-1:0] cmp_enable;
    logic [NUM_CMP-1:0] cmp_flag;
    logic [NUM_CMP-1:0] cmp_event;
    logic [NUM_CMP-1:0] cmp_irq_ch;

    // bus answer state
    logic [DATA_W-1:0] rdata_next;

    // two flops before the pin is looked at, third only for the edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_sync1_reg <= 1'b0;
            ext_sync2_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_sync1_reg <= ext_clk_pin;
            ext_sync2_reg <= ext_sync1_reg;
            ext_prev_reg <= ext_sync2_reg;
        end
    end

    // clock source selection for the 24-bit counter
    wire clk_src_sel = timer_ctrl_reg[CLK_SRC_SEL_BIT];
    wire ext_rise = ext_sync2_reg && !ext_prev_reg;
    wire timer_advance = clk_src_sel ? ext_rise : 1'b1;

    // 24-bit free-running counter
    step_counter #(
        .W(TIMER_W)
    ) timer_counter (
        .clk(clk),
        .nrst(nrst),
        .enable(timer_advance),
        .count(timer_count),
        .stepped(timer_stepped)
    );

    // pwm counters, each run by its own control bit
    genvar p;
    generate
        for (p = 0; p < NUM_PWM; p++) begin : g_pwm
            step_counter #(
                .W(PWM_W)
            ) pwm_counter (
                .clk(clk),
                .nrst(nrst),
                .enable(timer_ctrl_reg[PWM_RUN_LSB + p]),
                .count(pwm_count[p]),
                .stepped()
            );
        end
    endgenerate

    // apb phases: one wait state, effect at the edge pready is seen high
    wire access = psel && penable;
    wire answer_now = access && !pready;
    wire fire = access && pready;
    wire wr_fire = fire && pwrite;

    // address decode
    wire hit_cmp0_value = (paddr == COMPARE0_VALUE_ADDR);
    wire hit_cmp1_value = (paddr == COMPARE1_VALUE_ADDR);
    wire hit_cmp0_ctrl = (paddr == COMPARE0_CONTROL_ADDR);
    wire hit_cmp1_ctrl = (paddr == COMPARE1_CONTROL_ADDR);
    wire hit_pwm0 = (paddr == PWM0_COUNT_VALUE_ADDR);
    wire hit_pwm1 = (paddr == PWM1_COUNT_VALUE_ADDR);
    wire hit_pwm2 = (paddr == PWM2_COUNT_VALUE_ADDR);
    wire hit_pwm3 = (paddr == PWM3_COUNT_VALUE_ADDR);
    wire hit_timer_ctrl = (paddr == TIMER_CONTROL_ADDR);
    wire hit_status = (paddr == IRQ_STATUS_ADDR);
    wire hit_mask = (paddr == IRQ_MASK_ADDR);
    wire hit_timer_count = (paddr == TIMER_COUNT_ADDR);
    wire hit_pwm = hit_pwm0 || hit_pwm1 || hit_pwm2 || hit_pwm3;
    wire hit_cmp = hit_cmp0_value || hit_cmp1_value || hit_cmp0_ctrl || hit_cmp1_ctrl;
    wire hit_own = hit_timer_ctrl || hit_status || hit_mask || hit_timer_count;
    wire mapped = hit_cmp || hit_pwm || hit_own;

    // per-channel write strobes
    wire [NUM_CMP-1:0] value_wr = {wr_fire && hit_cmp1_value, wr_fire && hit_cmp0_value};
    wire [NUM_CMP-1:0] control_wr = {wr_fire && hit_cmp1_ctrl, wr_fire && hit_cmp0_ctrl};

    // the two compare channels
    genvar c;
    generate
        for (c = 0; c < NUM_CMP; c++) begin : g_cmp
            compare_channel channel (
                .clk(clk),
                .nrst(nrst),
                .timer_count(timer_count),
                .timer_stepped(timer_stepped),
                .value_wr(value_wr[c]),
                .control_wr(control_wr[c]),
                .wdata(pwdata),
                .compare_value_reg(cmp_value[c]),
                .compare_irq_enable_reg(cmp_enable[c]),
                .compare_event_flag_reg(cmp_flag[c]),
                .compare_event_reg(cmp_event[c]),
                .compare_irq_reg(cmp_irq_ch[c])
            );
        end
    endgenerate

    // channel requests leave straight from the channel flops
    assign cmp_irq = cmp_irq_ch;

    // timer control register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timer_ctrl_reg <= TIMER_CTRL_RESET;
        end else if (wr_fire && hit_timer_ctrl) begin
            timer_ctrl_reg <= pwdata[TIMER_CTRL_W-1:0];
        end
    end

    // interrupt mask register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_mask_reg <= IRQ_MASK_RESET;
        end else if (wr_fire && hit_mask) begin
            irq_mask_reg <= pwdata[NUM_CMP-1:0];
        end
    end

    // sticky status, write one to clear, a new event wins over the clear
    wire [NUM_CMP-1:0] status_w1c = (wr_fire && hit_status) ? pwdata[NUM_CMP-1:0] : '0;
    assign irq_status_next = cmp_event | (irq_status_reg & ~status_w1c);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    // block interrupt is registered from the next status value
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_next & irq_mask_reg);
        end
    end

    // read data for each group of registers
    wire [DATA_W-1:0] rd_cmp0_value = {8'h00, cmp_value[0]};
    wire [DATA_W-1:0] rd_cmp1_value = {8'h00, cmp_value[1]};
    wire [DATA_W-1:0] rd_cmp0_ctrl = {30'h00000000, cmp_enable[0], cmp_flag[0]};
    wire [DATA_W-1:0] rd_cmp1_ctrl = {30'h00000000, cmp_enable[1], cmp_flag[1]};
    wire [DATA_W-1:0] rd_pwm0 = {16'h0000, pwm_count[0]};
    wire [DATA_W-1:0] rd_pwm1 = {16'h0000, pwm_count[1]};
    wire [DATA_W-1:0] rd_pwm2 = {16'h0000, pwm_count[2]};
    wire [DATA_W-1:0] rd_pwm3 = {16'h0000, pwm_count[3]};
    wire [DATA_W-1:0] rd_timer_ctrl = {24'h000000, timer_ctrl_reg};
    wire [DATA_W-1:0] rd_status = {30'h00000000, irq_status_reg};
    wire [DATA_W-1:0] rd_mask = {30'h00000000, irq_mask_reg};
    wire [DATA_W-1:0] rd_timer_count = {8'h00, timer_count};

    // read select, unmapped reads as zero
    always_comb begin
        rdata_next = '0;
        if (hit_cmp0_value) begin
            rdata_next = rd_cmp0_value;
        end else if (hit_cmp1_value) begin
            rdata_next = rd_cmp1_value;
        end else if (hit_cmp0_ctrl) begin
            rdata_next = rd_cmp0_ctrl;
        end else if (hit_cmp1_ctrl) begin
            rdata_next = rd_cmp1_ctrl;
        end else if (hit_pwm0) begin
            rdata_next = rd_pwm0;
        end else if (hit_pwm1) begin
            rdata_next = rd_pwm1;
        end else if (hit_pwm2) begin
            rdata_next = rd_pwm2;
        end else if (hit_pwm3) begin
            rdata_next = rd_pwm3;
        end else if (hit_timer_ctrl) begin
            rdata_next = rd_timer_ctrl;
        end else if (hit_status) begin
            rdata_next = rd_status;
        end else if (hit_mask) begin
            rdata_next = rd_mask;
        end else if (hit_timer_count) begin
            rdata_next = rd_timer_count;
        end
    end

    // bus answer: ready one cycle into the access phase, dropped after it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (answer_now) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= pwrite ? '0 : rdata_next;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule

// *** verif/timer_compare_properties.sv ***
// port assertions of the output compare timer block
// assumes it is bound to timer_compare_top, apb3 master on clk
`timescale 1ns/1ns
module timer_compare_properties
    import timer_cmp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ext_clk_pin,
    input wire logic [NUM_CMP-1:0] cmp_irq,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // completed writes that switch a request off
    wire wr_done = psel && penable && pwrite && pready;
    wire en_bit = pwdata[CMP_IRQ_ENABLE_BIT];
    wire ctl0_off = wr_done && paddr == COMPARE0_CONTROL_ADDR && !en_bit;
    wire ctl1_off = wr_done && paddr == COMPARE1_CONTROL_ADDR && !en_bit;
    wire mask_off = wr_done && paddr == IRQ_MASK_ADDR && pwdata[1:0] == 2'h0;
    // bus timing and request relations
    property p_wait; psel && penable && !pready |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    property p_err; pslverr |-> pready; endproperty
    property p_access; pready |-> psel && penable; endproperty
    property p_misalign; pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
    property p_dis0; ctl0_off |=> !cmp_irq[0]; endproperty
    property p_dis1; ctl1_off |=> !cmp_irq[1]; endproperty
    property p_mask; mask_off |-> ##2 !irq; endproperty
    property p_rst; $rose(nrst) |-> !pready && cmp_irq == 2'h0 && !irq; endproperty
    property p_wrzero; wr_done |=> prdata == 32'h0; endproperty
    a_wait: assert property (p_wait) else $error("pready late");
    a_pulse: assert property (p_pulse) else $error("pready too long");
    a_err: assert property (p_err) else $error("pslverr alone");
    a_access: assert property (p_access) else $error("pready outside access");
    a_misalign: assert property (p_misalign) else $error("no error on hole");
    a_dis0: assert property (p_dis0) else $error("ch0 request stays");
    a_dis1: assert property (p_dis1) else $error("ch1 request stays");
    a_mask: assert property (p_mask) else $error("masked irq high");
    a_rst: assert property (p_rst) else $error("outputs after reset");
    a_wrzero: assert property (p_wrzero) else $error("prdata after write");
    c_irq0: cover property ($rose(cmp_irq[0]));
    c_irq1: cover property ($rose(cmp_irq[1]));
    c_err: cover property (pslverr);
endmodule
bind timer_compare_top timer_compare_properties u_props (.clk(clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
    .cmp_irq(cmp_irq), .irq(irq));

// *** verif/timer_compare_top_tb.sv ***
// self-checking bench of the output compare timer block
// assumes an apb slave that answers within twenty cycles of a request
`timescale 1ns/1ns
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); end end
module timer_compare_top_tb
    import timer_cmp_pkg::*;
    ;
    typedef struct packed {logic [31:0] a, rst, wd, rd; logic e;} row_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_clk_pin = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, rv, t, prdata;
    logic ev, pready, pslverr, irq;
    logic [1:0] cmp_irq;
    int error_cnt = 0, checks_done = 0;
    // address, reset value, write data, read back, error
    row_t rows[9] = '{
        '{COMPARE0_VALUE_ADDR, 32'h0, 32'hff123456, 32'h00123456, 1'b0},
        '{COMPARE1_VALUE_ADDR, 32'h0, 32'h00abcdef, 32'h00abcdef, 1'b0},
        '{COMPARE0_CONTROL_ADDR, 32'h0, 32'h6, 32'h2, 1'b0},
        '{COMPARE1_CONTROL_ADDR, 32'h0, 32'h2, 32'h2, 1'b0},
        '{IRQ_MASK_ADDR, 32'h0, 32'h3, 32'h3, 1'b0},
        '{PWM0_COUNT_VALUE_ADDR, 32'h0, 32'hffff, 32'h0, 1'b0},
        '{PWM3_COUNT_VALUE_ADDR, 32'h0, 32'hffff, 32'h0, 1'b0},
        '{32'hfff7fd10, 32'h0, 32'h5, 32'h0, 1'b1},
        '{32'hfff7fd25, 32'h0, 32'h5, 32'h0, 1'b1}
    };

    // clock
    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    timer_compare_top uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
        .cmp_irq(cmp_irq), .irq(irq));

    // verdict and end of run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            stop_test();
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [31:0] a);
        apb(a, 1'b0, 32'h0);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    // bounded wait for a channel request
    task automatic wait_irq(input int c);
        int n;
        n = 0;
        while (cmp_irq[c] !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) begin
            error_cnt++;
            stop_test();
        end
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            rd(rows[i].a);
            `CHK(rv, rows[i].rst)
            wr(rows[i].a, rows[i].wd);
            rd(rows[i].a);
            `CHK(rv, rows[i].rd)
            `CHK(ev, rows[i].e)
        end
        $display("register rows done");
        // channel 0 event, sticky flag, write zero keeps, write one clears
        rd(TIMER_COUNT_ADDR);
        wr(COMPARE0_VALUE_ADDR, {8'h0, rv[23:0] + 24'd60});
        wait_irq(0);
        `CHK(cmp_irq[0], 1'b1)
        rd(COMPARE0_CONTROL_ADDR);
        `CHK(rv, 32'h3)
        `CHK(irq, 1'b1)
        wr(COMPARE0_CONTROL_ADDR, 32'h0);
        rd(COMPARE0_CONTROL_ADDR);
        `CHK(rv, 32'h1)
        `CHK(cmp_irq[0], 1'b0)
        wr(COMPARE0_CONTROL_ADDR, 32'h3);
        rd(COMPARE0_CONTROL_ADDR);
        `CHK(rv, 32'h2)
        `CHK(cmp_irq[0], 1'b0)
        $display("channel 0 flag test done");
        // channel 1 flag cleared by rewriting its compare value
        rd(TIMER_COUNT_ADDR);
        wr(COMPARE1_VALUE_ADDR, {8'h0, rv[23:0] + 24'd60});
        wait_irq(1);
        wr(COMPARE1_CONTROL_ADDR, 32'h0);
        `CHK(cmp_irq[1], 1'b0)
        wr(COMPARE1_CONTROL_ADDR, 32'h2);
        `CHK(cmp_irq[1], 1'b1)
        wr(COMPARE1_VALUE_ADDR, 32'h00fff000);
        rd(COMPARE1_CONTROL_ADDR);
        `CHK(rv, 32'h2)
        `CHK(cmp_irq, 2'h0)
        $display("channel 1 rewrite test done");
        // status stays under mask, clears on write one
        wr(IRQ_MASK_ADDR, 32'h0);
        rd(IRQ_STATUS_ADDR);
        `CHK(rv, 32'h3)
        `CHK(irq, 1'b0)
        wr(IRQ_STATUS_ADDR, 32'h3);
        rd(IRQ_STATUS_ADDR);
        `CHK(rv, 32'h0)
        $display("interrupt status test done");
        // external clock source: counter moves only on pin edges
        wr(TIMER_CONTROL_ADDR, 32'h11);
        rd(TIMER_COUNT_ADDR);
        t = rv;
        rd(TIMER_COUNT_ADDR);
        `CHK(rv, t)
        repeat (5) begin
            ext_clk_pin <= 1'b1;
            repeat (3) @(posedge clk);
            ext_clk_pin <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        rd(TIMER_COUNT_ADDR);
        `CHK(rv, t + 32'd5)
        rd(PWM0_COUNT_VALUE_ADDR);
        `CHK(rv != 32'h0, 1'b1)
        $display("clock source test done");
        // reset in mid-run clears control state and requests
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        `CHK({cmp_irq, irq}, 3'h0)
        rd(COMPARE0_VALUE_ADDR);
        `CHK(rv, 32'h0)
        rd(COMPARE1_CONTROL_ADDR);
        `CHK(rv, 32'h0)
        rd(TIMER_CONTROL_ADDR);
        `CHK(rv, 32'h0)
        $display("mid-run reset test done");
        stop_test();
    end
endmodule
